// ==== inc/fieldbus_diag_pkg.sv ====
// constants for the fieldbus diagnostic and i/o parameter bank
package fieldbus_diag_pkg;
  // parameter logic addresses
  localparam logic [15:0] ADDR_INPUT_STATES      = 16'h1452;
  localparam logic [15:0] ADDR_OUTPUT_STATES     = 16'h145c;
  localparam logic [15:0] ADDR_ANALOG_STD        = 16'h1470;
  localparam logic [15:0] ADDR_ANALOG_PHYS       = 16'h147a;
  localparam logic [15:0] ADDR_FIELDBUS_ERR      = 16'h17a8;
  localparam logic [15:0] ADDR_NETWORK_STATE     = 16'h17a9;
  localparam logic [15:0] ADDR_TX_ERR_COUNTER    = 16'h17aa;
  localparam logic [15:0] ADDR_RX_ERR_COUNTER    = 16'h17ab;
  localparam logic [15:0] ADDR_LAST_DEVICE_ERR   = 16'h1bd1;
  localparam logic [15:0] ADDR_TX_PDO_COUNT      = 16'h330e;
  localparam logic [15:0] ADDR_RX_PDO_COUNT      = 16'h330f;
  // output_states field positions
  localparam int RELAY_LSB  = 0;
  localparam int DOUT_LSB   = 8;
  localparam int N_RELAYS   = 3;
  localparam int N_DOUTS    = 2;
  localparam int N_DINS     = 4;
  // network management states
  typedef enum logic [2:0] {
    state_bootup         = 3'h0,
    state_operational    = 3'h1,
    state_stopped        = 3'h2,
    state_preoperational = 3'h4
  } nmt_state_t;
  // fieldbus error codes
  localparam logic [15:0] ERR_NONE         = 16'h0000;
  localparam logic [15:0] ERR_BUS_OFF      = 16'h0001;
  localparam logic [15:0] ERR_NODE_GUARD   = 16'h0002;
  localparam logic [15:0] ERR_OVERRUN      = 16'h0003;
  localparam logic [15:0] ERR_HEARTBEAT    = 16'h0004;
  localparam logic [15:0] ERR_STATE_CHART  = 16'h0005;
  localparam logic [15:0] ERR_OVERRUN_ALT0 = 16'h0020;
  localparam logic [15:0] ERR_OVERRUN_ALT1 = 16'h0040;
  localparam logic [15:0] ERR_OVERRUN_ALT2 = 16'h0080;
  // last device error enumeration
  typedef enum logic [1:0] {
    no_error_value          = 2'h0,
    comm_interruption_error = 2'h1,
    fieldbus_init_error     = 2'h2
  } last_err_t;
  // analog input types
  typedef enum logic [1:0] {
    type_voltage           = 2'h0,
    type_thermistor        = 2'h1,
    platinum_sensor_type_a = 2'h2,
    platinum_sensor_type_b = 2'h3
  } analog_in_type_t;
  // raw analog is in 1 ohm steps for the thermistor; 0.01 kohm is ten of them
  localparam logic [15:0] THERM_DIVISOR = 16'h000a;
  // reset values
  localparam logic [15:0] RST_OUTPUT_STATES = 16'h0000;
  localparam logic [15:0] RST_WORD          = 16'h0000;
endpackage

// ==== rtl/din_sync.sv ====
// two-flop synchroniser for the digital input pins
`timescale 1ns/1ps
module din_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input  wire logic             clock_in,
  input  wire logic             rst_b_in,
  input  wire logic             ce_in,
  // pins and synchronised copy
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else if (ce_in) begin
      meta_q   <= pin_in;
      sync_out <= meta_q;
    end
  end
endmodule // din_sync

// ==== rtl/analog_scale.sv ====
// converts the raw analog sample to the physical value unit of the input type
`timescale 1ns/1ps
module analog_scale
  import fieldbus_diag_pkg::*;
(
  // clock and reset
  input  wire logic                              clock_in,
  input  wire logic                              rst_b_in,
  input  wire logic                              ce_in,
  // sample and type
  input  wire logic signed [15:0]                raw_in,
  input  wire fieldbus_diag_pkg::analog_in_type_t type_in,
  // scaled value, registered
  output logic signed [15:0]                     phys_out
);
  logic signed [15:0] phys_d;

  // platinum and voltage raw units already match their display unit
  assign phys_d = (type_in == type_thermistor) ?
                  16'(raw_in / $signed(THERM_DIVISOR)) : raw_in;

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      phys_out <= RST_WORD;
    end else if (ce_in) begin
      phys_out <= phys_d;
    end
  end
endmodule // analog_scale

// ==== rtl/fieldbus_diag_io_params.sv ====
// fieldbus diagnostic and i/o parameter bank with its parameter access port
`timescale 1ns/1ps
module fieldbus_diag_io_params
  import fieldbus_diag_pkg::*;
(
  // clock, reset, enable
  input  wire logic                                clock_in,
  input  wire logic                                rst_b_in,
  input  wire logic                                ce_in,
  // parameter access from the network protocol engine
  input  wire logic                                param_req_in,
  input  wire logic                                param_write_in,
  input  wire logic [15:0]                         param_addr_in,
  input  wire logic [15:0]                         param_wdata_in,
  output logic                                     param_ack_out,
  output logic                                     param_err_out,
  output logic      [15:0]                         param_rdata_out,
  // network management and protocol status
  input  wire fieldbus_diag_pkg::nmt_state_t       nmt_state_in,
  input  wire logic                                comm_start_in,
  input  wire logic                                fb_err_event_in,
  input  wire logic [15:0]                         fb_err_code_in,
  input  wire logic                                init_error_in,
  input  wire logic [15:0]                         tx_pdo_count_in,
  input  wire logic [15:0]                         rx_pdo_count_in,
  input  wire logic [15:0]                         tx_err_counter_in,
  input  wire logic [15:0]                         rx_err_counter_in,
  input  wire logic                                motor_running_in,
  // digital input pins
  input  wire logic [N_DINS-1:0]                   din_pin_in,
  // output assignment and internal function drive
  input  wire logic [N_RELAYS-1:0]                 relay_assigned_in,
  input  wire logic [N_RELAYS-1:0]                 relay_func_in,
  input  wire logic [N_DOUTS-1:0]                  dout_assigned_in,
  input  wire logic [N_DOUTS-1:0]                  dout_func_in,
  // analog input
  input  wire logic signed [15:0]                  analog_raw_in,
  input  wire logic signed [15:0]                  analog_std_in,
  input  wire fieldbus_diag_pkg::analog_in_type_t  analog_in_type_in,
  // physical outputs and fault
  output logic      [N_RELAYS-1:0]                 relay_out,
  output logic      [N_DOUTS-1:0]                  dout_out,
  output logic                                     comm_fault_out
);
  // ---- status mirrors
  nmt_state_t         nmt_q;
  logic [15:0]        tx_pdo_q;
  logic [15:0]        rx_pdo_q;
  logic [15:0]        tx_err_q;
  logic [15:0]        rx_err_q;
  logic [15:0]        fb_err_q;
  logic [15:0]        fb_err_d;
  last_err_t          last_err_q;
  last_err_t          last_err_d;
  logic [N_DINS-1:0]  din_sync;
  logic signed [15:0] analog_phys;
  logic signed [15:0] analog_std_q;
  logic               running_q;
  logic               fault_q;
  logic               fault_d;

  // ---- network-driven outputs
  logic [N_RELAYS-1:0] relay_net_q;
  logic [N_RELAYS-1:0] relay_net_d;
  logic [N_DOUTS-1:0]  dout_net_q;
  logic [N_DOUTS-1:0]  dout_net_d;
  logic [N_RELAYS-1:0] relay_d;
  logic [N_DOUTS-1:0]  dout_d;

  // ---- access port
  logic        ack_q;
  logic        err_q;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic        hit_any;
  logic        wr_outputs;
  logic [15:0] out_word;
  logic [15:0] in_word;

  // ---- event decode
  wire nmt_changed   = (nmt_state_in != nmt_q);
  wire comm_interrupt = nmt_changed && running_q;
  wire comm_error    = comm_interrupt || fb_err_event_in || init_error_in;
  wire err_known     = (fb_err_code_in == ERR_BUS_OFF) ||
                       (fb_err_code_in == ERR_NODE_GUARD) ||
                       (fb_err_code_in == ERR_OVERRUN) ||
                       (fb_err_code_in == ERR_HEARTBEAT) ||
                       (fb_err_code_in == ERR_STATE_CHART) ||
                       (fb_err_code_in == ERR_OVERRUN_ALT0) ||
                       (fb_err_code_in == ERR_OVERRUN_ALT1) ||
                       (fb_err_code_in == ERR_OVERRUN_ALT2);
  wire err_needs_init = (fb_err_code_in == ERR_NODE_GUARD) ||
                        (fb_err_code_in == ERR_HEARTBEAT);
  wire err_take      = fb_err_event_in && err_known;

  // an event with a known code in the start cycle wins, so a fresh error is never lost
  assign fb_err_d = err_take      ? fb_err_code_in :
                    comm_start_in ? ERR_NONE : fb_err_q;

  // init error outranks an interruption seen in the same cycle
  assign last_err_d = (init_error_in || (err_take && err_needs_init)) ?
                      fieldbus_init_error :
                      comm_interrupt ? comm_interruption_error : last_err_q;

  // fault holds until the next communication start, unless a new error arrives
  assign fault_d = comm_error ? 1'b1 : comm_start_in ? 1'b0 : fault_q;

  // ---- network write to the output word
  assign wr_outputs = param_req_in && param_write_in &&
                      (param_addr_in == ADDR_OUTPUT_STATES);

  // writes land only on unassigned outputs; errors drop all network drive
  assign relay_net_d = comm_error ? '0 :
                       wr_outputs ?
                       ((param_wdata_in[RELAY_LSB +: N_RELAYS] & ~relay_assigned_in) |
                        (relay_net_q & relay_assigned_in)) : relay_net_q;
  assign dout_net_d  = comm_error ? '0 :
                       wr_outputs ?
                       ((param_wdata_in[DOUT_LSB +: N_DOUTS] & ~dout_assigned_in) |
                        (dout_net_q & dout_assigned_in)) : dout_net_q;

  // internal functions own assigned outputs
  assign relay_d = (relay_func_in & relay_assigned_in) |
                   (relay_net_d & ~relay_assigned_in);
  assign dout_d  = (dout_func_in & dout_assigned_in) |
                   (dout_net_d & ~dout_assigned_in);

  // ---- read decode
  always_comb begin
    out_word = '0;
    in_word  = '0;
    out_word[RELAY_LSB +: N_RELAYS] = relay_out;
    out_word[DOUT_LSB +: N_DOUTS]   = dout_out;
    in_word[N_DINS-1:0]             = din_sync;
  end

  assign hit_any = (param_addr_in == ADDR_INPUT_STATES) ||
                   (param_addr_in == ADDR_OUTPUT_STATES) ||
                   (param_addr_in == ADDR_ANALOG_STD) ||
                   (param_addr_in == ADDR_ANALOG_PHYS) ||
                   (param_addr_in == ADDR_FIELDBUS_ERR) ||
                   (param_addr_in == ADDR_NETWORK_STATE) ||
                   (param_addr_in == ADDR_TX_ERR_COUNTER) ||
                   (param_addr_in == ADDR_RX_ERR_COUNTER) ||
                   (param_addr_in == ADDR_LAST_DEVICE_ERR) ||
                   (param_addr_in == ADDR_TX_PDO_COUNT) ||
                   (param_addr_in == ADDR_RX_PDO_COUNT);

  always_comb begin
    rdata_d = '0;
    unique case (param_addr_in)
      ADDR_INPUT_STATES:    rdata_d = in_word;
      ADDR_OUTPUT_STATES:   rdata_d = out_word;
      ADDR_ANALOG_STD:      rdata_d = analog_std_q;
      ADDR_ANALOG_PHYS:     rdata_d = analog_phys;
      ADDR_FIELDBUS_ERR:    rdata_d = fb_err_q;
      ADDR_NETWORK_STATE:   rdata_d = {13'h0000, nmt_q};
      ADDR_TX_ERR_COUNTER:  rdata_d = tx_err_q;
      ADDR_RX_ERR_COUNTER:  rdata_d = rx_err_q;
      ADDR_LAST_DEVICE_ERR: rdata_d = {14'h0000, last_err_q};
      ADDR_TX_PDO_COUNT:    rdata_d = tx_pdo_q;
      ADDR_RX_PDO_COUNT:    rdata_d = rx_pdo_q;
      default:              rdata_d = '0;
    endcase
  end

  // ---- submodules
  din_sync #(
    .WIDTH (N_DINS)
  ) u_din_sync (
    .clock_in (clock_in),
    .rst_b_in (rst_b_in),
    .ce_in    (ce_in),
    .pin_in   (din_pin_in),
    .sync_out (din_sync)
  );

  analog_scale u_analog_scale (
    .clock_in (clock_in),
    .rst_b_in (rst_b_in),
    .ce_in    (ce_in),
    .raw_in   (analog_raw_in),
    .type_in  (analog_in_type_in),
    .phys_out (analog_phys)
  );

  // ---- status registers, one cycle behind their sources
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      nmt_q        <= state_bootup;
      tx_pdo_q     <= RST_WORD;
      rx_pdo_q     <= RST_WORD;
      tx_err_q     <= RST_WORD;
      rx_err_q     <= RST_WORD;
      analog_std_q <= RST_WORD;
      running_q    <= 1'b0;
    end else if (ce_in) begin
      nmt_q        <= nmt_state_in;
      tx_pdo_q     <= tx_pdo_count_in;
      rx_pdo_q     <= rx_pdo_count_in;
      tx_err_q     <= tx_err_counter_in;
      rx_err_q     <= rx_err_counter_in;
      analog_std_q <= analog_std_in;
      running_q    <= motor_running_in;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fb_err_q   <= ERR_NONE;
      last_err_q <= no_error_value;
      fault_q    <= 1'b0;
    end else if (ce_in) begin
      fb_err_q   <= fb_err_d;
      last_err_q <= last_err_d;
      fault_q    <= fault_d;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      relay_net_q <= RST_OUTPUT_STATES[RELAY_LSB +: N_RELAYS];
      dout_net_q  <= RST_OUTPUT_STATES[DOUT_LSB +: N_DOUTS];
      relay_out   <= RST_OUTPUT_STATES[RELAY_LSB +: N_RELAYS];
      dout_out    <= RST_OUTPUT_STATES[DOUT_LSB +: N_DOUTS];
    end else if (ce_in) begin
      relay_net_q <= relay_net_d;
      dout_net_q  <= dout_net_d;
      relay_out   <= relay_d;
      dout_out    <= dout_d;
    end
  end

  // answer one cycle after the request; unknown addresses or writes to
  // read-only words answer with the error flag and zero data
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_q   <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= RST_WORD;
    end else if (ce_in) begin
      ack_q   <= param_req_in;
      err_q   <= param_req_in && (!hit_any || (param_write_in && !wr_outputs));
      rdata_q <= (param_req_in && !param_write_in) ? rdata_d : RST_WORD;
    end
  end

  assign param_ack_out   = ack_q;
  assign param_err_out   = err_q;
  assign param_rdata_out = rdata_q;
  assign comm_fault_out  = fault_q;

  // ---- checks
  // the flops still hold reset at the release edge, so mirror checks start one edge later
  a_nmt_encoding:
  assert property (@(posedge clock_in) disable iff (!rst_b_in)
    ce_in && rst_b_in |=> (nmt_q == $past(nmt_state_in)))
  else $error("network state does not follow its source");

  a_interrupt_raised:
  assert property (@(posedge clock_in) disable iff (!rst_b_in)
    ce_in && running_q && nmt_changed && !init_error_in && !fb_err_event_in
    |=> (last_err_q == comm_interruption_error) && comm_fault_out)
  else $error("state change while running did not raise interruption");

  a_pdo_counts:
  assert property (@(posedge clock_in) disable iff (!rst_b_in)
    ce_in && rst_b_in |=> (tx_pdo_q == $past(tx_pdo_count_in)) &&
              (rx_pdo_q == $past(rx_pdo_count_in)))
  else $error("pdo count mirror stale");

  a_err_latched:
  assert property (@(posedge clock_in) disable iff (!rst_b_in)
    ce_in && err_take |=> (fb_err_q == $past(fb_err_code_in)))
  else $error("fieldbus error code not latched");

  a_overrun_alt:
  assert property (@(posedge clock_in) disable iff (!rst_b_in)
    ce_in && fb_err_event_in && (fb_err_code_in == ERR_OVERRUN_ALT2)
    |=> (fb_err_q == ERR_OVERRUN_ALT2))
  else $error("alternative overrun value dropped");

  a_start_clears:
  assert property (@(posedge clock_in) disable iff (!rst_b_in)
    ce_in && comm_start_in && !fb_err_event_in |=> (fb_err_q == ERR_NONE))
  else $error("error code not cleared at communication start");

  a_err_counters:
  assert property (@(posedge clock_in) disable iff (!rst_b_in)
    ce_in && rst_b_in ##1 (param_req_in && !param_write_in &&
               param_addr_in == ADDR_RX_ERR_COUNTER && ce_in)
    |=> (param_rdata_out == $past(rx_err_counter_in, 2)))
  else $error("receive error counter read mismatch");

  a_init_error:
  assert property (@(posedge clock_in) disable iff (!rst_b_in)
    ce_in && init_error_in |=> (last_err_q == fieldbus_init_error))
  else $error("init error not recorded");

  a_outputs_dropped:
  assert property (@(posedge clock_in) disable iff (!rst_b_in)
    ce_in && comm_error |=> ((relay_out & ~$past(relay_assigned_in)) == '0) &&
                            ((dout_out & ~$past(dout_assigned_in)) == '0))
  else $error("network outputs kept after communication error");

  a_din_mirror:
  assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (ce_in && rst_b_in) [*3] |-> (din_sync == $past(din_pin_in, 2)))
  else $error("digital input image wrong");

  a_assigned_ignored:
  assert property (@(posedge clock_in) disable iff (!rst_b_in)
    ce_in && wr_outputs && !comm_error
    |=> ((relay_out & $past(relay_assigned_in)) ==
         ($past(relay_func_in) & $past(relay_assigned_in))))
  else $error("write reached an assigned relay");

  a_free_written:
  assert property (@(posedge clock_in) disable iff (!rst_b_in)
    ce_in && wr_outputs && !comm_error
    |=> ((dout_out & ~$past(dout_assigned_in)) ==
         ($past(param_wdata_in[DOUT_LSB +: N_DOUTS]) & ~$past(dout_assigned_in))))
  else $error("write did not reach a free digital output");

  a_std_value:
  assert property (@(posedge clock_in) disable iff (!rst_b_in)
    ce_in && rst_b_in |=> (analog_std_q == $past(analog_std_in)))
  else $error("standardized analog value stale");

  a_tx_err_read:
  assert property (@(posedge clock_in) disable iff (!rst_b_in)
    ce_in && rst_b_in ##1 (param_req_in && !param_write_in &&
                           param_addr_in == ADDR_TX_ERR_COUNTER && ce_in)
    |=> (param_rdata_out == $past(tx_err_counter_in, 2)))
  else $error("transmit error counter read mismatch");

  a_out_word_read:
  assert property (@(posedge clock_in) disable iff (!rst_b_in)
    ce_in && param_req_in && !param_write_in && (param_addr_in == ADDR_OUTPUT_STATES)
    |=> (param_rdata_out[RELAY_LSB +: N_RELAYS] == $past(relay_out)) &&
        (param_rdata_out[DOUT_LSB +: N_DOUTS] == $past(dout_out)))
  else $error("output word read does not show the outputs");

  a_input_read_only:
  assert property (@(posedge clock_in) disable iff (!rst_b_in)
    ce_in && rst_b_in && param_req_in && param_write_in &&
    (param_addr_in == ADDR_INPUT_STATES)
    |=> param_err_out && (param_rdata_out == RST_WORD))
  else $error("write to input states was not refused");

  a_phys_passthru:
  assert property (@(posedge clock_in) disable iff (!rst_b_in)
    ce_in && rst_b_in && (analog_in_type_in != type_thermistor)
    |=> (analog_phys == $past(analog_raw_in)))
  else $error("physical value not in the unit of its input type");
endmodule // fieldbus_diag_io_params

// ==== verification/net_master_model.sv ====
// network master model issuing parameter accesses toward the bank
`timescale 1ns/1ps
module net_master_model (
  // clock
  input  wire logic        clock_in,
  // access port toward the bank
  output logic             param_req_out,
  output logic             param_write_out,
  output logic [15:0]      param_addr_out,
  output logic [15:0]      param_wdata_out
);
  initial begin
    param_req_out   = 1'b0;
    param_write_out = 1'b0;
    param_addr_out  = 16'h0000;
    param_wdata_out = 16'h0000;
  end
  // one-cycle request; released qualifiers are inverted so stale values are never trusted
  task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] wdata);
    @(posedge clock_in);
    param_req_out   <= 1'b1;
    param_write_out <= wr;
    param_addr_out  <= addr;
    param_wdata_out <= wdata;
    @(posedge clock_in);
    param_req_out   <= 1'b0;
    param_write_out <= ~wr;
    param_addr_out  <= ~addr;
    param_wdata_out <= ~wdata;
  endtask
endmodule // net_master_model

// ==== verification/testbench.sv ====
// self-checking bench for the fieldbus diagnostic parameter bank
`timescale 1ns/1ps
module testbench;
  import fieldbus_diag_pkg::*;
  logic                clock_in, rst_b_in, ce_in, req, wr, ack, err, fault;
  logic                comm_start, fb_ev, init_err, motor;
  logic [15:0]         addr, wdata, rdata, fb_code, tx_pdo, rx_pdo, tx_err, rx_err, r;
  nmt_state_t          nmt;
  logic [N_DINS-1:0]   din;
  logic [N_RELAYS-1:0] r_asg, r_fn, relay_out;
  logic [N_DOUTS-1:0]  d_asg, d_fn, dout_out;
  logic signed [15:0]  a_raw, a_std;
  analog_in_type_t     a_type;
  logic [4:0]          e5;
  logic [16:0]         exp_q[$];
  int                  mismatches, samples_checked, seed;
  nmt_state_t          states[4] = '{state_operational, state_stopped,
                                     state_preoperational, state_bootup};
  logic [7:0]          codes[8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h20, 8'h40, 8'h80};

  net_master_model u_net_master_model (.clock_in(clock_in), .param_req_out(req),
    .param_write_out(wr), .param_addr_out(addr), .param_wdata_out(wdata));
  fieldbus_diag_io_params u_fieldbus_diag_io_params (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
    .param_req_in(req), .param_write_in(wr), .param_addr_in(addr), .param_wdata_in(wdata),
    .param_ack_out(ack), .param_err_out(err), .param_rdata_out(rdata),
    .nmt_state_in(nmt), .comm_start_in(comm_start), .fb_err_event_in(fb_ev),
    .fb_err_code_in(fb_code), .init_error_in(init_err), .tx_pdo_count_in(tx_pdo),
    .rx_pdo_count_in(rx_pdo), .tx_err_counter_in(tx_err), .rx_err_counter_in(rx_err),
    .motor_running_in(motor), .din_pin_in(din), .relay_assigned_in(r_asg),
    .relay_func_in(r_fn), .dout_assigned_in(d_asg), .dout_func_in(d_fn),
    .analog_raw_in(a_raw), .analog_std_in(a_std), .analog_in_type_in(a_type),
    .relay_out(relay_out), .dout_out(dout_out), .comm_fault_out(fault));

  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask

  // note the expected answer, then let the master issue the access
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
                     input logic e, input logic [15:0] x);
    exp_q.push_back({e, x});
    u_net_master_model.access(w, a, d);
  endtask

  task automatic pulse_err(input logic [15:0] code);
    fb_ev   <= 1'b1;
    fb_code <= code;
    tick(1);
    fb_ev   <= 1'b0;
    fb_code <= 16'h0007;
    tick(2);
  endtask

  task automatic end_of_test();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // every answer strobe consumes the oldest note; an unexpected strobe compares against x
  always @(posedge clock_in) begin
    if (ack === 1'b1) begin
      check({err, rdata}, (exp_q.size() > 0) ? exp_q.pop_front() : 17'bx);
    end
  end

  initial begin
    tick(20000);
    mismatches++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    seed = 32'hd1531c09;
    {rst_b_in, ce_in, comm_start, fb_ev, init_err, motor} = 6'b010000;
    nmt = state_bootup;
    {fb_code, tx_pdo, rx_pdo, tx_err, rx_err} = '0;
    {din, r_asg, r_fn, d_asg, d_fn, a_type} = '0;
    {a_raw, a_std} = '0;
    tick(6);
    rst_b_in <= 1'b1;
    acc(0, ADDR_LAST_DEVICE_ERR, 0, 0, 16'h0000);
    acc(0, ADDR_FIELDBUS_ERR, 0, 0, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      nmt <= states[i];
      tick(2);
      acc(0, ADDR_NETWORK_STATE, 0, 0, {13'h0, states[i]});
    end
    {tx_pdo, rx_pdo} <= $random(seed);
    tx_err <= 16'hffff;
    rx_err <= 16'($random(seed));
    din    <= 4'($random(seed));
    tick(5);
    acc(0, ADDR_TX_PDO_COUNT, 0, 0, tx_pdo);
    acc(0, ADDR_RX_PDO_COUNT, 0, 0, rx_pdo);
    acc(0, ADDR_TX_ERR_COUNTER, 0, 0, tx_err);
    acc(0, ADDR_RX_ERR_COUNTER, 0, 0, rx_err);
    acc(0, ADDR_INPUT_STATES, 0, 0, {12'h0, din});
    acc(1, ADDR_INPUT_STATES, 16'hffff, 1, 16'h0000);
    acc(0, 16'h1453, 0, 1, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      {r_asg, r_fn, d_asg, d_fn} <= 10'($random(seed));
      r = 16'($random(seed));
      tick(1);
      e5 = {(r_asg & r_fn) | (~r_asg & r[2:0]), (d_asg & d_fn) | (~d_asg & r[9:8])};
      acc(1, ADDR_OUTPUT_STATES, r, 0, 16'h0000);
      tick(2);
      check({12'h0, relay_out, dout_out}, {12'h0, e5});
      acc(0, ADDR_OUTPUT_STATES, 0, 0, {6'h0, e5[1:0], 5'h0, e5[4:2]});
    end
    {r_asg, d_asg} <= '0;
    motor <= 1'b1;
    tick(2);
    nmt <= state_operational;
    tick(3);
    check({16'h0, fault}, 17'h1);
    acc(0, ADDR_LAST_DEVICE_ERR, 0, 0, {14'h0, comm_interruption_error});
    motor <= 1'b0;
    comm_start <= 1'b1;
    tick(1);
    comm_start <= 1'b0;
    tick(2);
    check({16'h0, fault}, 17'h0);
    acc(1, ADDR_OUTPUT_STATES, 16'h0307, 0, 16'h0000);
    tick(2);
    check({12'h0, relay_out, dout_out}, 17'h1f);
    pulse_err(ERR_HEARTBEAT);
    check({12'h0, relay_out, dout_out}, 17'h0);
    acc(0, ADDR_LAST_DEVICE_ERR, 0, 0, {14'h0, fieldbus_init_error});
    foreach (codes[i]) begin
      pulse_err({8'h0, codes[i]});
      acc(0, ADDR_FIELDBUS_ERR, 0, 0, {8'h0, codes[i]});
    end
    pulse_err(16'h0009);
    acc(0, ADDR_FIELDBUS_ERR, 0, 0, ERR_OVERRUN_ALT2);
    comm_start <= 1'b1;
    tick(1);
    comm_start <= 1'b0;
    tick(2);
    acc(0, ADDR_FIELDBUS_ERR, 0, 0, ERR_NONE);
    tick(2);
    ce_in <= 1'b0;
    pulse_err(ERR_BUS_OFF);
    ce_in <= 1'b1;
    acc(0, ADDR_FIELDBUS_ERR, 0, 0, ERR_NONE);
    for (int i = 0; i < 4; i++) begin
      a_type <= analog_in_type_t'(i);
      r = 16'($random(seed)) & 16'h7fff;
      a_raw <= r;
      a_std <= ~r;
      tick(3);
      acc(0, ADDR_ANALOG_PHYS, 0, 0, (i == 1) ? r / THERM_DIVISOR : r);
      acc(0, ADDR_ANALOG_STD, 0, 0, ~r);
    end
    acc(1, ADDR_OUTPUT_STATES, 16'h0307, 0, 16'h0000);
    tick(3);
    check({12'h0, relay_out, dout_out}, 17'h1f);
    rst_b_in <= 1'b0;
    tick(2);
    rst_b_in <= 1'b1;
    check({12'h0, relay_out, dout_out}, 17'h0);
    check({16'h0, fault}, 17'h0);
    acc(0, ADDR_LAST_DEVICE_ERR, 0, 0, {14'h0, no_error_value});
    for (int i = 0; i < 20 && exp_q.size() > 0; i++) tick(1);
    check(17'(exp_q.size()), 17'h0);
    end_of_test();
  end
endmodule // testbench
